/* hw/hbfd_ctrl.v */
// H-bridge gate sequencing and fast output discharge sequencer with APB slave
`include "hbfd_regs.vh"

module hbfd_ctrl #(
  parameter RATIO_W = `HBFD_RATIO_W,
  parameter DLY_W = `HBFD_DLY_W
) (
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  // Frame end of the command link
  input wire cs_rise_i,
  // Analog comparator results
  input wire vin_low_i,
  input wire vin_high_i,
  input wire cur_peak_i,
  input wire cur_valley_i,
  input wire cur_zero_i,
  input wire vout_target_i,
  input wire s2g_dec_i,
  input wire s2g_det_i,
  input wire soft_start_done_i,
  input wire dim_pwm_input_i,
  input wire sw_cycle_start_i,
  // Gate drives
  output reg input_high_switch_o,
  output reg input_low_switch_o,
  output reg output_low_switch_o,
  output reg output_high_switch_o,
  // Discharge analog controls
  output reg rev_current_o,
  output reg limit_two_thirds_o,
  output reg limit_half_o,
  output reg comp_discharge_o,
  output reg comp_sink_reduce_o,
  output reg ratio_load_num_o,
  output reg [RATIO_W-1:0] ratio_value_o,
  output reg discharge_done_o
);

  // Discharge sequencer walk-through, one phase per state:
  //   Idle      - normal regulation in the mode picked by the comparators
  //   Wait SS   - start accepted before soft start ended; gates stay off
  //   Discharge - inductor current reversed, output charge pushed to input
  //   Recover   - target reached, current brought back towards zero
  //   Brake     - both low sides on until the preparation time expires
  //   Done      - one-cycle done indication, switching resumes next cycle
  // Numerator above denominator skips the output discharge entirely:
  // the sequencer then passes through Discharge for a single cycle with
  // no reverse current and brakes for the whole preparation time.
  // Any short to ground, or the falling short threshold, returns to Idle
  // from every busy phase, with no done indication.
  //
  // Preparation time is counted in switching periods, not clock cycles,
  // so the count follows the switching frequency whatever it is set to.
  // The counter starts over when a discharge is accepted and again while
  // soft start still runs, so a deferred start gets its full time.
  //
  // Limitation: the block has no view of the analog sample and hold;
  // the host must space the two ratio writes far enough apart itself.
  // Limitation: a second start while busy keeps the phase but restarts the preparation count and reloads the compensation-only choice.

  // Sequencer phases
  localparam PH_IDLE = 3'd0;
  localparam PH_WAIT_SS = 3'd1;
  localparam PH_DISCH = 3'd2;
  localparam PH_RECOVER = 3'd3;
  localparam PH_BRAKE = 3'd4;
  localparam PH_DONE = 3'd5;

  reg [7:0] setup_reg;
  reg [DLY_W-1:0] timing_reg;
  reg enable_reg;
  reg [RATIO_W-1:0] denom_reg;
  reg start_pend_reg;
  reg pwm_seen_reg;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;
  reg [DLY_W:0] prep_cnt_reg;
  reg prep_done_reg;
  reg comp_only_reg;
  reg [1:0] mode_reg;
  reg energize_reg;

  wire wr_en;
  wire rd_en;
  wire busy;
  wire start_ok;
  wire [DLY_W:0] prep_total;
  // Compensation-only decision valid in the start cycle itself
  wire comp_only_now;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign wr_en = psel_i & penable_i & pwrite_i & ce_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i & ce_i;
  assign busy = (phase_reg != PH_IDLE) && (phase_reg != PH_DONE);
  // Two base periods on top of the delay field; one spare bit so 255 + 2 fits
  assign prep_total = {1'b0, timing_reg} + {{(DLY_W-1){1'b0}}, 2'b10};

  // Start cycle uses the fresh ratio compare, later cycles the stored one.
  // Without this the first discharge cycle would follow the previous run.
  assign comp_only_now = start_ok ? (ratio_value_o > denom_reg) : comp_only_reg;

  // Register map notes:
  //   Setup  - ratio field, start bit, half-limit bit, sink-reduce bit
  //   Timing - preparation delay in switching periods, two added on top
  //   Status - done, busy, mode, phase and dim-seen, read only
  //   Ctrl   - enable; clearing it also forgets the dim-seen flag
  // A setup write without the start bit loads the denominator; a write
  // with the start bit keeps the denominator and presents the numerator.
  // Register writes; a start write arms the sequencer until the frame ends
  always @(posedge clk_i) begin
    if (srst_i) begin
      setup_reg <= `HBFD_SETUP_RST;
      timing_reg <= {DLY_W{1'b0}};
      enable_reg <= `HBFD_CTRL_RST;
      denom_reg <= {RATIO_W{1'b0}};
      start_pend_reg <= 1'b0;
      ratio_value_o <= {RATIO_W{1'b0}};
      ratio_load_num_o <= 1'b0;
    end else if (ce_i) begin
      if (cs_rise_i) begin
        start_pend_reg <= 1'b0;
      end
      if (wr_en && paddr_i == `HBFD_SETUP_OFS) begin
        setup_reg <= pwdata_i[7:0];
        ratio_value_o <= pwdata_i[RATIO_W-1:0];
        ratio_load_num_o <= pwdata_i[`HBFD_START_BIT];
        if (pwdata_i[`HBFD_START_BIT]) begin
          start_pend_reg <= 1'b1;
        end else begin
          denom_reg <= pwdata_i[RATIO_W-1:0];
        end
      end
      if (wr_en && paddr_i == `HBFD_TIMING_OFS) begin
        timing_reg <= pwdata_i[DLY_W-1:0];
      end
      if (wr_en && paddr_i == `HBFD_CTRL_OFS) begin
        enable_reg <= pwdata_i[`HBFD_CTRL_EN_BIT];
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    prdata_o = 32'h0000_0000;
    if (rd_en) begin
      case (paddr_i)
        `HBFD_SETUP_OFS: prdata_o = {24'h00_0000, setup_reg};
        `HBFD_TIMING_OFS: prdata_o = {{(32-DLY_W){1'b0}}, timing_reg};
        `HBFD_STATUS_OFS: prdata_o = {23'h00_0000, pwm_seen_reg, 1'b0, phase_reg,
                                       mode_reg, busy, discharge_done_o};
        `HBFD_CTRL_OFS: prdata_o = {31'h0000_0000, enable_reg};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // Dim input seen high since enable; cleared while disabled
  always @(posedge clk_i) begin
    if (srst_i) begin
      pwm_seen_reg <= 1'b0;
    end else if (ce_i) begin
      if (!enable_reg) begin
        pwm_seen_reg <= 1'b0;
      end else if (dim_pwm_input_i) begin
        pwm_seen_reg <= 1'b1;
      end
    end
  end

  // Frame end with a pending start; dim level and overvoltage not checked
  assign start_ok = cs_rise_i & start_pend_reg & enable_reg & pwm_seen_reg & ~s2g_det_i;

  // Phase transitions are decided combinationally so that the gate
  // drives, registered below, change in the same edge as the phase.
  // The abort test sits after the case so it overrides every busy branch.
  // Done is left for Idle after one cycle unless a new start arrives in
  // that very cycle, which is then taken like a start from Idle.
  // Sequencer next phase
  always @* begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE, PH_DONE: begin
        if (start_ok) begin
          phase_next = soft_start_done_i ? PH_DISCH : PH_WAIT_SS;
        end else if (phase_reg == PH_DONE) begin
          phase_next = PH_IDLE;
        end
      end
      PH_WAIT_SS: begin
        if (soft_start_done_i) begin
          phase_next = PH_DISCH;
        end
      end
      PH_DISCH: begin
        if (comp_only_reg) begin
          phase_next = PH_BRAKE;
        end else if (vout_target_i) begin
          phase_next = PH_RECOVER;
        end
      end
      PH_RECOVER: begin
        if (cur_zero_i) begin
          phase_next = PH_BRAKE;
        end
      end
      PH_BRAKE: begin
        if (prep_done_reg) begin
          phase_next = PH_DONE;
        end
      end
      default: phase_next = PH_IDLE;
    endcase
    // Short to ground or falling threshold aborts any running sequence
    if (busy && (s2g_det_i || s2g_dec_i)) begin
      phase_next = PH_IDLE;
    end
  end

  // Phase register, preparation counter in switching periods
  always @(posedge clk_i) begin
    if (srst_i) begin
      phase_reg <= PH_IDLE;
      prep_cnt_reg <= {(DLY_W+1){1'b0}};
      prep_done_reg <= 1'b0;
      comp_only_reg <= 1'b0;
      discharge_done_o <= 1'b0;
    end else if (ce_i) begin
      phase_reg <= phase_next;
      discharge_done_o <= (phase_next == PH_DONE);
      if (start_ok) begin
        comp_only_reg <= comp_only_now;
      end
      if (phase_reg == PH_WAIT_SS || phase_next == PH_WAIT_SS || start_ok) begin
        prep_cnt_reg <= {(DLY_W+1){1'b0}};
        prep_done_reg <= 1'b0;
      end else if (busy && !prep_done_reg && sw_cycle_start_i) begin
        prep_cnt_reg <= prep_cnt_reg + 1'b1;
        if (prep_cnt_reg + 1'b1 == prep_total) begin
          prep_done_reg <= 1'b1;
        end
      end
    end
  end

  // Changing mode mid-period could leave a half-finished energize phase,
  // so the comparators are only looked at on the period start pulse.
  // Energize is the first part of each period; the current comparator
  // of the active mode ends it, valley for buck, peak otherwise.
  // Mode choice from input/output comparison, at cycle boundaries only
  always @(posedge clk_i) begin
    if (srst_i) begin
      mode_reg <= `HBFD_MODE_BB;
      energize_reg <= 1'b0;
    end else if (ce_i) begin
      if (sw_cycle_start_i) begin
        energize_reg <= 1'b1;
        if (vin_low_i) begin
          mode_reg <= `HBFD_MODE_BOOST;
        end else if (vin_high_i) begin
          mode_reg <= `HBFD_MODE_BUCK;
        end else begin
          mode_reg <= `HBFD_MODE_BB;
        end
      end else if ((mode_reg == `HBFD_MODE_BUCK) ? cur_valley_i : cur_peak_i) begin
        energize_reg <= 1'b0;
      end
    end
  end

  // Gate priorities: disabled or waiting for soft start beats everything,
  // then brake and done, then discharge and recovery, then the regulation
  // modes. Every branch drives at most one switch of each pair, so a
  // pair is never shorted across the rail whatever the inputs do.
  // The limit selects and reverse enable are gated by the compensation
  // only decision, so a ratio above one never reverses the current.
  // Gate drives and analog controls per phase and mode
  always @(posedge clk_i) begin
    if (srst_i) begin
      input_high_switch_o <= 1'b0;
      input_low_switch_o <= 1'b0;
      output_low_switch_o <= 1'b0;
      output_high_switch_o <= 1'b0;
      rev_current_o <= 1'b0;
      limit_two_thirds_o <= 1'b0;
      limit_half_o <= 1'b0;
      comp_discharge_o <= 1'b0;
      comp_sink_reduce_o <= 1'b0;
    end else if (ce_i) begin
      rev_current_o <= (phase_next == PH_DISCH) && !comp_only_now;
      limit_two_thirds_o <= (phase_next == PH_DISCH) && !comp_only_now &&
                            !setup_reg[`HBFD_HALF_BIT];
      limit_half_o <= (phase_next == PH_DISCH) && !comp_only_now &&
                      setup_reg[`HBFD_HALF_BIT];
      comp_discharge_o <= (phase_next == PH_DISCH) || (phase_next == PH_RECOVER) ||
                          (phase_next == PH_BRAKE);
      comp_sink_reduce_o <= busy && setup_reg[`HBFD_SINK_BIT];
      // Gates stay off while a deferred start waits for soft start
      if (!enable_reg || phase_next == PH_WAIT_SS) begin
        input_high_switch_o <= 1'b0;
        input_low_switch_o <= 1'b0;
        output_low_switch_o <= 1'b0;
        output_high_switch_o <= 1'b0;
      end else if (phase_next == PH_BRAKE || phase_next == PH_DONE) begin
        // Brake-low: both low sides hold the inductor at zero current
        input_high_switch_o <= 1'b0;
        input_low_switch_o <= 1'b1;
        output_low_switch_o <= 1'b1;
        output_high_switch_o <= 1'b0;
      end else if (phase_next == PH_DISCH || phase_next == PH_RECOVER) begin
        // Reverse boost: output high side pulls charge back to the input
        input_high_switch_o <= 1'b1;
        input_low_switch_o <= 1'b0;
        output_low_switch_o <= ~energize_reg;
        output_high_switch_o <= energize_reg;
      end else if (mode_reg == `HBFD_MODE_BOOST) begin
        input_high_switch_o <= 1'b1;
        input_low_switch_o <= 1'b0;
        output_low_switch_o <= energize_reg;
        output_high_switch_o <= ~energize_reg;
      end else if (mode_reg == `HBFD_MODE_BUCK) begin
        input_high_switch_o <= ~energize_reg;
        input_low_switch_o <= energize_reg;
        output_low_switch_o <= 1'b0;
        output_high_switch_o <= 1'b1;
      end else begin
        // Energize on input high plus output low, then direct transfer phase
        input_high_switch_o <= 1'b1;
        input_low_switch_o <= 1'b0;
        output_low_switch_o <= energize_reg;
        output_high_switch_o <= ~energize_reg;
      end
    end
  end

endmodule

/* hw/hbfd_regs.vh */
// Register offsets, field positions, reset values and timing counts for hbfd
`ifndef HBFD_REGS_VH
`define HBFD_REGS_VH

// Register byte offsets on APB
`define HBFD_SETUP_OFS 12'h000
`define HBFD_TIMING_OFS 12'h004
`define HBFD_STATUS_OFS 12'h008
`define HBFD_CTRL_OFS 12'h00c

// Setup register fields
`define HBFD_RATIO_LSB 0
`define HBFD_RATIO_W 5
`define HBFD_START_BIT 5
`define HBFD_HALF_BIT 6
`define HBFD_SINK_BIT 7

// Timing register field
`define HBFD_DLY_W 8

// Status register fields
`define HBFD_ST_DONE_BIT 0
`define HBFD_ST_BUSY_BIT 1
`define HBFD_ST_MODE_LSB 2
`define HBFD_ST_PHASE_LSB 4
`define HBFD_ST_PWMSEEN_BIT 8

// Control register fields
`define HBFD_CTRL_EN_BIT 0

// Reset values
`define HBFD_SETUP_RST 8'h00
`define HBFD_TIMING_RST 8'h00
`define HBFD_CTRL_RST 1'b0

// Preparation time base, in switching periods
`define HBFD_PREP_BASE 2

// Regulation modes
`define HBFD_MODE_BOOST 2'd0
`define HBFD_MODE_BB 2'd1
`define HBFD_MODE_BUCK 2'd2

`endif

/* tb/hbfd_ctrl_sva.sv */
// Port-level assertions for the gate and discharge sequencer
module hbfd_ctrl_sva (
  input wire clk_i,
  input wire srst_i,
  input wire s2g_det_i,
  input wire pslverr_o,
  input wire input_high_switch_o,
  input wire input_low_switch_o,
  input wire output_low_switch_o,
  input wire output_high_switch_o,
  input wire rev_current_o,
  input wire limit_two_thirds_o,
  input wire limit_half_o,
  input wire discharge_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // A pair shorted across the rail would be destructive
  in_pair_a: assert property (!(input_high_switch_o && input_low_switch_o))
    else $error("input pair both on");
  out_pair_a: assert property (!(output_low_switch_o && output_high_switch_o))
    else $error("output pair both on");
  done_pulse_a: assert property (discharge_done_o |=> !discharge_done_o)
    else $error("done held too long");
  half_only_a: assert property (limit_half_o |-> rev_current_o)
    else $error("half limit outside discharge");
  limit_on_a: assert property (rev_current_o |-> limit_two_thirds_o || limit_half_o)
    else $error("reverse current without limit");
  s2g_abort_a: assert property (s2g_det_i |-> ##[1:2] !rev_current_o)
    else $error("discharge not aborted on short");
  brake_done_a: assert property ($rose(discharge_done_o) |->
    $past(input_low_switch_o) && $past(output_low_switch_o))
    else $error("done without brake");
  no_err_a: assert property (!pslverr_o)
    else $error("slave error raised");
  c_done: cover property (discharge_done_o);
  c_rev: cover property ($rose(rev_current_o));
  c_half: cover property (limit_half_o);
endmodule

bind hbfd_ctrl hbfd_ctrl_sva u_sva (.*);

/* tb/hbfd_plant.sv */
// Power stage model: switching period pulses and current comparators
module hbfd_plant (
  input wire clk_i,
  input wire rev_current_i,
  output logic sw_cycle_start_o,
  output logic cur_peak_o,
  output logic cur_valley_o,
  output logic cur_zero_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph = 3'h0;
  // Eight clocks per period keeps prep counts short
  always @(posedge clk_i) begin
    ph <= ph + 3'h1;
    cur_zero_o <= !rev_current_i;
  end
  assign sw_cycle_start_o = (ph == 3'h0);
  assign cur_peak_o = (ph >= 3'h3);
  assign cur_valley_o = (ph >= 3'h5);
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the discharge sequencer
`include "hbfd_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata_o, exp_q[$];
  logic cs_rise = 0, vlo = 0, vhi = 0, tgt = 0, s2g = 0, ssd = 1, dim = 0;
  logic sw, pk, vl, cz, ih, il, ol, oh, rev, pready_o, done, lt, lh, csr, rln, dec = 0;
  logic [4:0] rv;
  int fail_count = 0, n_compared = 0, ndone = 0, pcnt = 0, pe = 0, d, b, h, co = 0;
  always #4 clk_i = ~clk_i;
  hbfd_plant u_plant (.clk_i(clk_i), .rev_current_i(rev), .sw_cycle_start_o(sw),
    .cur_peak_o(pk), .cur_valley_o(vl), .cur_zero_o(cz));
  hbfd_ctrl dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(), .cs_rise_i(cs_rise),
    .vin_low_i(vlo), .vin_high_i(vhi), .cur_peak_i(pk), .cur_valley_i(vl),
    .cur_zero_i(cz), .vout_target_i(tgt), .s2g_dec_i(dec), .s2g_det_i(s2g),
    .soft_start_done_i(ssd), .dim_pwm_input_i(dim), .sw_cycle_start_i(sw),
    .input_high_switch_o(ih), .input_low_switch_o(il), .output_low_switch_o(ol),
    .output_high_switch_o(oh), .rev_current_o(rev), .limit_two_thirds_o(lt),
    .limit_half_o(lh), .comp_discharge_o(), .comp_sink_reduce_o(csr),
    .ratio_load_num_o(rln), .ratio_value_o(rv), .discharge_done_o(done));
  task chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Setup, access, then hold until pready is seen high
  task apb(input w, input [11:0] a, input [31:0] dv);
    @(posedge clk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= dv;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    psel <= 0; penable <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  // Denominator, delay, then numerator with start, then frame end
  task start(input [31:0] num, input [31:0] dl);
    apb(1, `HBFD_SETUP_OFS, 32'h06);
    apb(1, `HBFD_TIMING_OFS, dl);
    repeat (10) @(posedge clk_i);
    apb(1, `HBFD_SETUP_OFS, num | 32'h20);
    @(posedge clk_i) cs_rise <= 1;
    @(posedge clk_i) begin cs_rise <= 0; pcnt <= 0; end
  endtask
  task go;
    @(posedge clk_i) srst_i <= 1;
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    apb(1, `HBFD_CTRL_OFS, 32'h1);
  endtask
  // Reads are scored against the oldest expectation, done pulses against the period count pe
  always @(posedge clk_i) begin
    if (psel && penable && pready_o && !pwrite) chk(prdata_o, exp_q.pop_front());
    if (done === 1'b1) begin
      ndone++;
      chk((pcnt >= pe) ? pe : pcnt, pe);
      chk(tgt | co, 1);
    end
    if (sw) pcnt++;
  end
  initial begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial begin
    void'($urandom(63));
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    rd(`HBFD_SETUP_OFS, 0);
    rd(`HBFD_TIMING_OFS, 0);
    rd(`HBFD_CTRL_OFS, 0);
    rd(12'h010, 0);
    // Never-high dim input blocks the discharge after enable
    apb(1, `HBFD_CTRL_OFS, 32'h1);
    start(2, 0);
    repeat (100) @(posedge clk_i);
    chk(ndone, 0);
    go();
    dim <= 1;
    for (int m = 0; m < 3; m++) begin
      vlo <= (m == 0);
      vhi <= (m == 2);
      repeat (20) @(posedge clk_i);
      if (m == 0) chk({ih, il}, 2'b10);
      if (m == 2) chk({ol, oh}, 2'b01);
      d = $urandom % 4;
      pe = 2 + d;
      b = ndone;
      h = (m == 2) ? 0 : $urandom % 4;
      co = (m == 2);
      start((m == 2) ? 7 : 2 | (h << 6), d);
      repeat (2) @(posedge clk_i);
      chk(rv, (m == 2) ? 7 : 2);
      chk(rln, 1);
      chk(rev, m != 2);
      chk(lt, (m != 2) && !h[0]);
      chk(lh, h[0]);
      chk(csr, h[1]);
      dim <= $urandom % 2;
      repeat (10 + $urandom % 60) @(posedge clk_i);
      tgt <= 1;
      for (int i = 0; i < 300 && ndone == b; i++) @(posedge clk_i);
      chk(ndone, b + 1);
      tgt <= 0;
    end
    // Start during soft start waits with gates off, then completes
    b = ndone;
    co = 0;
    pe = 3;
    ssd <= 0;
    start(3, 1);
    repeat (40) @(posedge clk_i);
    chk(ndone, b);
    chk({ih, il, ol, oh}, 4'h0);
    ssd <= 1;
    repeat (20) @(posedge clk_i);
    tgt <= 1;
    for (int i = 0; i < 300 && ndone == b; i++) @(posedge clk_i);
    chk(ndone, b + 1);
    tgt <= 0;
    // Falling short threshold ends the discharge with no done
    b = ndone;
    start(2, 3);
    repeat (10) @(posedge clk_i);
    dec <= 1;
    repeat (100) @(posedge clk_i);
    chk(ndone, b);
    chk(rev, 0);
    dec <= 0;
    // Short to ground in mid-run aborts with no done
    b = ndone;
    start(2, 3);
    repeat (10) @(posedge clk_i);
    s2g <= 1;
    repeat (100) @(posedge clk_i);
    chk(ndone, b);
    end_sim;
  end
endmodule
